// [design/iap_flash_sequencer.sv]
// In-application programming sequencer for the on-chip flash array
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Mode 001 erases tagged page on launch; clear bit empties buffer.
// - Mode 000 selects programming of the write buffer.
// - Program launch copies buffered words to flash, then self-clears.
// - CPU is stalled while a launched operation runs.
// - Erase/program need modify-enable; software may clear it freely.
// - Erase removes a whole page whenever a buffer word is tagged.
// - Program writes only the tagged buffer words, all in one page, never past it.
// - Mode 011 with read enable: read launch loads data registers.
// - Read launch bit returns low after three instruction cycles.
// - Reads need no modify-enable.
// - Buffer holds 32 words, page chosen by address bits 11 to 5.
// - High byte write advances buffer index, saturating at 31.
// - Mode 110 plus unlock bit starts timer; six key bytes unlock.
// - Correct key sets modify-enable automatically.
module iap_flash_sequencer
  import iap_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU hold
  output logic cpu_stall,
  // Flash array
  output logic [11:0] flash_addr,
  output logic [15:0] flash_wdata,
  output logic flash_erase,
  output logic flash_prog,
  output logic flash_read,
  input wire logic flash_done,
  input wire logic [15:0] flash_rdata
);
  import iap_pkg::*;

  seq_state_t state_reg, state_next;
  logic [2:0] operation_select_reg;
  logic unlock_start_bit_reg, read_enable_bit_reg, read_launch_bit_reg;
  logic program_launch_bit_reg, modify_enable_flag_reg;
  logic [7:0] addr_low_reg, addr_high_reg, word_low_reg, word_high_reg;
  logic [47:0] key_reg;
  logic [5:0] key_seen_reg;
  logic [4:0] buf_idx_reg, scan_idx_reg;
  logic [15:0] timer_reg;
  logic [7:0] rdata_reg;
  logic [11:0] flash_addr_reg;
  logic [15:0] flash_wdata_reg;
  logic erase_p_reg, prog_p_reg, read_p_reg;

  // Register write decode
  wire wr_ctrl0 = reg_wr && reg_addr == CTRL0_OFS;
  wire wr_ctrl1 = reg_wr && reg_addr == CTRL1_OFS;
  wire wr_alow = reg_wr && reg_addr == ADDR_LOW_OFS;
  wire wr_ahigh = reg_wr && reg_addr == ADDR_HIGH_OFS;
  wire wr_wlow = reg_wr && reg_addr == WORD_LOW_OFS;
  wire wr_whigh = reg_wr && reg_addr == WORD_HIGH_OFS;
  wire wr_key = reg_wr && reg_addr >= KEY_FIRST_OFS &&
                reg_addr <= KEY_LAST_OFS;
  wire [2:0] key_idx = 3'(reg_addr - KEY_FIRST_OFS);
  wire buf_clear = wr_ctrl1 && reg_wdata[CLEAR_BIT];

  // Mode and launch qualification
  wire [11:0] cur_addr = {addr_high_reg[3:0], addr_low_reg};
  wire [6:0] page_sel = cur_addr[11:5];
  wire idle = state_reg == S_IDLE;
  wire mode_erase = operation_select_reg == MODE_ERASE;
  wire mode_prog = operation_select_reg == MODE_PROGRAM;
  wire mode_read = operation_select_reg == MODE_READ;
  wire mode_unlock = operation_select_reg == MODE_UNLOCK;
  wire launch_ok = modify_enable_flag_reg && (mode_erase || mode_prog);
  wire launch_bad = program_launch_bit_reg && !launch_ok;
  wire read_ok = read_launch_bit_reg && read_enable_bit_reg && mode_read;
  wire read_bad = read_launch_bit_reg && !read_ok;
  // Unlock only starts from idle, so a running read keeps its timer
  wire unlock_go = wr_ctrl0 && idle && reg_wdata[UNLOCK_BIT] &&
                   !unlock_start_bit_reg;

  // Unlock key check
  wire key_full = &(key_seen_reg | (wr_key ? 6'(1 << key_idx) : 6'h00));
  wire [47:0] key_now = wr_key ?
    (key_reg & ~(48'hff << (8 * (5 - key_idx)))) |
    (48'(reg_wdata) << (8 * (5 - key_idx))) : key_reg;
  wire unlock_hit = unlock_start_bit_reg && mode_unlock && key_full &&
                    key_now == UNLOCK_KEY;
  wire unlock_timeout = unlock_start_bit_reg && timer_reg == 16'h0000;

  // Buffer wiring
  wire [15:0] buf_rdata;
  wire buf_rtag, buf_any;
  wire last_scan = scan_idx_reg == LAST_WORD;
  // Erase with nothing tagged stays idle, so its launch bit must drop here
  wire erase_empty = program_launch_bit_reg && launch_ok && mode_erase &&
                     !buf_any;

  iap_write_buffer iap_write_buffer_i (
    .mclk(mclk),
    .reset(reset),
    .clear(buf_clear),
    .wr_en(idle && wr_whigh),
    .wr_idx(buf_idx_reg),
    .wr_data({reg_wdata, word_low_reg}),
    .rd_idx(scan_idx_reg),
    .rd_data(buf_rdata),
    .rd_tag(buf_rtag),
    .any_tag(buf_any)
  );

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
        if (program_launch_bit_reg && launch_ok)
          state_next = mode_erase ? (buf_any ? S_ERASE : S_IDLE) : S_SCAN;
        else if (read_ok)
          state_next = S_READ;
      S_ERASE:
        if (flash_done)
          state_next = S_IDLE;
      S_SCAN:
        if (buf_rtag)
          state_next = S_PROG;
        else if (last_scan)
          state_next = S_IDLE;
      S_PROG:
        if (flash_done)
          state_next = last_scan ? S_IDLE : S_SCAN;
      S_READ:
        if (timer_reg == 16'h0001)
          state_next = S_IDLE;
    endcase
  end

  // Hold the CPU for the whole of a running operation
  assign cpu_stall = !idle;
  assign flash_addr = flash_addr_reg;
  assign flash_wdata = flash_wdata_reg;
  assign flash_erase = erase_p_reg;
  assign flash_prog = prog_p_reg;
  assign flash_read = read_p_reg;
  assign reg_rdata = rdata_reg;

  // State and flash requests
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg <= S_IDLE;
      erase_p_reg <= 1'b0;
      prog_p_reg <= 1'b0;
      read_p_reg <= 1'b0;
      flash_addr_reg <= 12'h000;
      flash_wdata_reg <= 16'h0000;
      scan_idx_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      // Erase names only the page; the array wipes all 32 words
      erase_p_reg <= idle && state_next == S_ERASE;
      prog_p_reg <= state_reg == S_SCAN && buf_rtag;
      read_p_reg <= idle && state_next == S_READ;
      if (idle && state_next == S_ERASE)
        flash_addr_reg <= {page_sel, 5'h00};
      else if (idle && state_next == S_READ)
        flash_addr_reg <= cur_addr;
      else if (state_reg == S_SCAN && buf_rtag)
      begin
        flash_addr_reg <= {page_sel, scan_idx_reg}; // stays in page
        flash_wdata_reg <= buf_rdata;
      end
      if (idle)
        scan_idx_reg <= 5'h00;
      else if ((state_reg == S_SCAN && !buf_rtag) ||
               (state_reg == S_PROG && flash_done))
        scan_idx_reg <= last_scan ? scan_idx_reg : scan_idx_reg + 5'h01;
    end
  end

  // Shared timer: unlock window, or read latency
  always_ff @(posedge mclk)
  begin
    if (reset)
      timer_reg <= 16'h0000;
    else if (idle && state_next == S_READ)
      timer_reg <= 16'(READ_CYCLES);
    else if (unlock_go)
      timer_reg <= 16'(UNLOCK_CYCLES);
    else if (timer_reg != 16'h0000)
      timer_reg <= timer_reg - 16'h0001;
  end

  // Control bits; hardware drops launch bits when work ends
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      operation_select_reg <= OPSEL_RESET;
      unlock_start_bit_reg <= 1'b0;
      read_enable_bit_reg <= 1'b0;
      read_launch_bit_reg <= 1'b0;
      program_launch_bit_reg <= 1'b0;
      modify_enable_flag_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl0 && idle)
      begin
        operation_select_reg <= reg_wdata[OPSEL_LSB +: 3];
        read_enable_bit_reg <= reg_wdata[RDEN_BIT];
        read_launch_bit_reg <= reg_wdata[RDLAUNCH_BIT];
        program_launch_bit_reg <= reg_wdata[PLAUNCH_BIT];
        unlock_start_bit_reg <= reg_wdata[UNLOCK_BIT];
      end
      else
      begin
        if (launch_bad || erase_empty || (!idle && state_next == S_IDLE &&
            state_reg != S_READ))
          program_launch_bit_reg <= 1'b0;
        if (read_bad || (state_reg == S_READ && state_next == S_IDLE))
          read_launch_bit_reg <= 1'b0;
        if (unlock_hit || unlock_timeout)
          unlock_start_bit_reg <= 1'b0;
      end
      // Hardware set beats a software clear in the same cycle
      if (unlock_hit)
        modify_enable_flag_reg <= 1'b1;
      else if (wr_ctrl0 && idle && !reg_wdata[MODEN_BIT])
        modify_enable_flag_reg <= 1'b0;
    end
  end

  // Address, data and key registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      addr_low_reg <= BYTE_RESET;
      addr_high_reg <= BYTE_RESET;
      word_low_reg <= BYTE_RESET;
      word_high_reg <= BYTE_RESET;
      buf_idx_reg <= 5'h00;
      key_reg <= 48'h0;
      key_seen_reg <= 6'h00;
    end
    else
    begin
      if (wr_alow)
      begin
        addr_low_reg <= reg_wdata;
        buf_idx_reg <= reg_wdata[4:0]; // new start word
      end
      if (wr_ahigh)
        addr_high_reg <= reg_wdata;
      if (wr_wlow)
        word_low_reg <= reg_wdata; // low byte staged first
      if (wr_whigh)
      begin
        word_high_reg <= reg_wdata;
        if (buf_idx_reg != LAST_WORD)
          buf_idx_reg <= buf_idx_reg + 5'h01;
      end
      if (state_reg == S_READ && state_next == S_IDLE)
      begin
        word_low_reg <= flash_rdata[7:0];
        word_high_reg <= flash_rdata[15:8];
      end
      // A new unlock attempt forgets earlier key bytes
      if (unlock_go)
        key_seen_reg <= 6'h00;
      else if (unlock_hit || unlock_timeout)
        key_seen_reg <= 6'h00;
      else if (wr_key)
        key_seen_reg <= key_seen_reg | 6'(1 << key_idx);
      if (wr_key)
        key_reg <= key_now;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata_reg <= BYTE_RESET;
    else if (reg_rd)
      unique case (reg_addr)
        CTRL0_OFS:
          rdata_reg <= {modify_enable_flag_reg, program_launch_bit_reg,
                        read_launch_bit_reg, read_enable_bit_reg,
                        unlock_start_bit_reg, operation_select_reg};
        ADDR_LOW_OFS: rdata_reg <= addr_low_reg;
        ADDR_HIGH_OFS: rdata_reg <= {4'h0, addr_high_reg[3:0]};
        WORD_LOW_OFS: rdata_reg <= word_low_reg;
        WORD_HIGH_OFS: rdata_reg <= word_high_reg;
        default: rdata_reg <= BYTE_RESET;
      endcase
    else
      rdata_reg <= BYTE_RESET;
  end
endmodule
`default_nettype wire

// [design/iap_pkg.sv]
// Constants shared by the flash sequencer and its write buffer
package iap_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int READ_TIME_NS = 3 * INSTR_CYCLE_NS;
  localparam int READ_CYCLES = (READ_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                               READ_TIME_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_TIME_NS = 50000;
  localparam int UNLOCK_CYCLES = (UNLOCK_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 UNLOCK_TIME_NS / CLK_PERIOD_NS;
  // Register offsets
  localparam logic [3:0] CTRL0_OFS = 4'h0;
  localparam logic [3:0] CTRL1_OFS = 4'h1;
  localparam logic [3:0] ADDR_LOW_OFS = 4'h2;
  localparam logic [3:0] ADDR_HIGH_OFS = 4'h3;
  localparam logic [3:0] WORD_LOW_OFS = 4'h4;
  localparam logic [3:0] WORD_HIGH_OFS = 4'h5;
  localparam logic [3:0] KEY_FIRST_OFS = 4'h6;
  localparam logic [3:0] KEY_LAST_OFS = 4'hb;
  // Control register 0 fields
  localparam int OPSEL_LSB = 0;
  localparam int UNLOCK_BIT = 3;
  localparam int RDEN_BIT = 4;
  localparam int RDLAUNCH_BIT = 5;
  localparam int PLAUNCH_BIT = 6;
  localparam int MODEN_BIT = 7;
  // Control register 1 fields
  localparam int CLEAR_BIT = 0;
  // Operation modes
  localparam logic [2:0] MODE_PROGRAM = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // Unlock key, low registers 1..3 then high registers 1..3
  localparam logic [47:0] UNLOCK_KEY = 48'h00_0d_c3_04_09_40;
  // Page geometry
  localparam int PAGE_WORDS = 32;
  localparam logic [4:0] LAST_WORD = 5'h1f;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] OPSEL_RESET = 3'h0;
  typedef enum logic [2:0] {S_IDLE, S_ERASE, S_SCAN, S_PROG, S_READ} seq_state_t;
endpackage

// [design/iap_write_buffer.sv]
// One page write buffer: 32 words, each with a tag bit
`timescale 1ns/1ps
`default_nettype none
module iap_write_buffer
  import iap_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Fill side
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [15:0] wr_data,
  // Drain side
  input wire logic [4:0] rd_idx,
  output logic [15:0] rd_data,
  output logic rd_tag,
  output logic any_tag
);
  logic [15:0] word_reg [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] tag_reg;

  // Read mux over flop storage
  assign rd_data = word_reg[rd_idx];
  assign rd_tag = tag_reg[rd_idx];
  assign any_tag = |tag_reg;

  // Clear empties data and tags; a write in the same cycle wins
  always_ff @(posedge mclk)
  begin
    if (reset || clear)
    begin
      tag_reg <= '0;
      for (int i = 0; i < PAGE_WORDS; i++)
        word_reg[i] <= 16'h0000;
    end
    if (wr_en && !reset)
    begin
      word_reg[wr_idx] <= wr_data;
      tag_reg[wr_idx] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [test/iap_flash_sequencer_asserts.sv]
// Port-level checks for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module iap_flash_sequencer_asserts
  import iap_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Stall and flash side
  input wire logic cpu_stall,
  input wire logic [11:0] flash_addr,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_read,
  input wire logic flash_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic rd_go;
  logic [6:0] prog_page;
  logic prog_seen;
  // Read launch written while idle, with the modify flag in any state
  assign rd_go = reg_wr && reg_addr == CTRL0_OFS && !cpu_stall &&
    reg_wdata[2:0] == MODE_READ && reg_wdata[RDEN_BIT] &&
    reg_wdata[RDLAUNCH_BIT];
  // Page of the first word of a launch; later words must stay on it
  always_ff @(posedge mclk)
  begin
    if (reset || !cpu_stall)
      prog_seen <= 1'b0;
    else if (flash_prog)
      prog_seen <= 1'b1;
    if (flash_prog && !prog_seen)
      prog_page <= flash_addr[11:5];
  end
  sequence s_erase_wait;
    cpu_stall throughout (##[0:40] flash_done);
  endsequence
  property p_erase_hold;
    flash_erase |=> s_erase_wait ##1 !cpu_stall;
  endproperty
  property p_erase_page;
    flash_erase |-> flash_addr[4:0] == 5'h00 && cpu_stall;
  endproperty
  property p_read_len;
    // Twelve stalled samples from the pulse, then free: READ_CYCLES is 12
    flash_read |-> cpu_stall [*6] ##1 cpu_stall [*6] ##1 !cpu_stall;
  endproperty
  property p_read_start;
    rd_go |-> ##[1:3] flash_read;
  endproperty
  property p_prog_stall;
    flash_prog |-> cpu_stall && !flash_erase && !flash_read;
  endproperty
  property p_prog_page;
    flash_prog && prog_seen |-> flash_addr[11:5] == prog_page;
  endproperty
  property p_one_op;
    flash_erase || flash_read |=> !flash_erase && !flash_prog && !flash_read;
  endproperty
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_erase_hold: assert property (p_erase_hold)
    else $error("erase stall not held until done");
  a_erase_page: assert property (p_erase_page)
    else $error("erase not page aligned");
  a_read_len: assert property (p_read_len)
    else $error("read length wrong");
  a_read_start: assert property (p_read_start)
    else $error("read launch ignored");
  a_prog_stall: assert property (p_prog_stall)
    else $error("program without stall");
  a_prog_page: assert property (p_prog_page)
    else $error("program left the page");
  a_one_op: assert property (p_one_op)
    else $error("overlapping flash operations");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
endmodule
bind iap_flash_sequencer iap_flash_sequencer_asserts
  iap_flash_sequencer_asserts_i (.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
  .flash_addr(flash_addr), .flash_erase(flash_erase),
  .flash_prog(flash_prog), .flash_read(flash_read),
  .flash_done(flash_done));
`default_nettype wire

// [test/flash_array_model.sv]
// Behavioural flash array: page erase, word program, word read
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Sequencer side
  input wire logic [11:0] flash_addr,
  input wire logic [15:0] flash_wdata,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_read,
  output logic flash_done,
  output logic [15:0] flash_rdata,
  // Busy time of erase and program in clocks, at least 1
  input wire logic [7:0] lat
);
  logic [15:0] mem [0:4095];
  logic [7:0] cnt;
  logic er;
  logic [11:0] a;
  logic [15:0] d;
  int n_ops = 0;
  // One operation at a time; array changes only when done pulses
  always @(posedge mclk)
  begin
    flash_done <= 1'b0;
    if (reset)
      cnt <= 8'h00;
    else if (cnt != 8'h00)
    begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01)
      begin
        flash_done <= 1'b1;
        if (er)
          for (int k = 0; k < 32; k++)
            mem[{a[11:5], k[4:0]}] <= 16'h0000;
        else
          mem[a] <= d;
      end
    end
    else if (flash_erase || flash_prog)
    begin
      cnt <= lat;
      er <= flash_erase;
      a <= flash_addr;
      d <= flash_wdata;
      n_ops++;
    end
    // Read data held until the next read
    if (flash_read)
      flash_rdata <= mem[flash_addr];
  end
endmodule
`default_nettype wire

// [test/iap_flash_sequencer_tb.sv]
// Self-checking bench for the flash sequencer with an array model
`timescale 1ns/1ps
`default_nettype none
module iap_flash_sequencer_tb;
  import iap_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, lat = 8'h02, reg_rdata;
  logic cpu_stall, flash_erase, flash_prog, flash_read, flash_done;
  logic [11:0] flash_addr;
  logic [15:0] flash_wdata, flash_rdata;
  int failures = 0, n_compared = 0;
  iap_flash_sequencer iap_flash_sequencer_i (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_read(flash_read), .flash_done(flash_done),
    .flash_rdata(flash_rdata));
  flash_array_model flash_array_model_i (.mclk(mclk), .reset(reset),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_read(flash_read), .flash_done(flash_done),
    .flash_rdata(flash_rdata), .lat(lat));
  initial forever #25 mclk = ~mclk; // full rate throughout
  task automatic chk(input string what, input logic [15:0] e, got);
    n_compared++;
    if (got !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask
  // Bus cycles start after an edge, so strobes never double up
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("register read", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic set_addr(input logic [11:0] a);
    wr(ADDR_HIGH_OFS, {4'h0, a[11:8]});
    wr(ADDR_LOW_OFS, a[7:0]);
  endtask
  task automatic put_word(input logic [15:0] w);
    wr(WORD_LOW_OFS, w[7:0]);
    wr(WORD_HIGH_OFS, w[15:8]);
  endtask
  // Bounded wait: a stall that never ends fails the stall end check after 3000 clocks
  task automatic launch(input logic [7:0] c);
    wr(CTRL0_OFS, c);
    repeat (2) @(posedge mclk);
    #1;
    for (int i = 0; i < 3000 && cpu_stall !== 1'b0; i++)
      @(posedge mclk) #1;
    chk("stall end", 16'h0000, {15'h0, cpu_stall});
  endtask
  function automatic logic [15:0] m(input logic [11:0] a);
    return flash_array_model_i.mem[a];
  endfunction
  task automatic t_locked();
    flash_array_model_i.mem[12'h065] = 16'h1234;
    set_addr(12'h060);
    put_word(16'hffff);
    launch(8'h41);
    launch(8'h40);
    rdc(CTRL0_OFS, 8'h00);
    chk("array word", 16'h1234, m(12'h065));
    chk("ops", 16'h0000, 16'(flash_array_model_i.n_ops));
  endtask
  task automatic t_unlock();
    wr(CTRL0_OFS, 8'h0e);
    wr(KEY_FIRST_OFS, 8'h55);
    repeat (UNLOCK_CYCLES + 8) @(posedge mclk);
    rdc(CTRL0_OFS, 8'h06);
    wr(CTRL0_OFS, 8'h0e);
    for (int k = 0; k < 6; k++)
      wr(KEY_FIRST_OFS + 4'(k), UNLOCK_KEY[47 - 8 * k -: 8]);
    rdc(CTRL0_OFS, 8'h86);
  endtask
  task automatic t_erase();
    lat <= 8'h14;
    flash_array_model_i.mem[12'h07f] = 16'h5555;
    flash_array_model_i.mem[12'h080] = 16'haaaa;
    wr(CTRL1_OFS, 8'h01);
    set_addr(12'h067);
    put_word(16'h0000);
    launch(8'hc1);
    rdc(CTRL0_OFS, 8'h81);
    chk("page start", 16'h0000, m(12'h060));
    chk("page end", 16'h0000, m(12'h07f));
    chk("next page", 16'haaaa, m(12'h080));
    lat <= 8'h02;
  endtask
  task automatic t_prog();
    wr(CTRL1_OFS, 8'h01);
    launch(8'hc1);
    rdc(CTRL0_OFS, 8'h81);
    chk("ops", 16'h0001, 16'(flash_array_model_i.n_ops));
    wr(CTRL0_OFS, 8'h80);
    set_addr(12'h07e);
    put_word(16'hbeef);
    put_word(16'hcafe);
    put_word(16'hf00d);
    launch(8'hc0);
    rdc(CTRL0_OFS, 8'h80);
    chk("word 30", 16'hbeef, m(12'h07e));
    chk("word 31", 16'hf00d, m(12'h07f));
    chk("untagged", 16'h0000, m(12'h060));
    chk("ops", 16'h0003, 16'(flash_array_model_i.n_ops));
    wr(CTRL1_OFS, 8'h01);
    set_addr(12'h063);
    put_word(16'h1357);
    launch(8'hc0);
    chk("word 3", 16'h1357, m(12'h063));
    chk("ops", 16'h0004, 16'(flash_array_model_i.n_ops));
  endtask
  // Reads run with the modify flag cleared; then a program must fail
  task automatic t_read();
    wr(CTRL0_OFS, 8'h03);
    wr(CTRL0_OFS, 8'h13);
    set_addr(12'h07e);
    launch(8'h33);
    rdc(WORD_LOW_OFS, 8'hef);
    rdc(WORD_HIGH_OFS, 8'hbe);
    rdc(CTRL0_OFS, 8'h13);
    wr(CTRL1_OFS, 8'h01);
    wr(CTRL0_OFS, 8'h00);
    put_word(16'h0f0f);
    launch(8'h40);
    chk("ops", 16'h0004, 16'(flash_array_model_i.n_ops));
  endtask
  task automatic end_sim();
    $display("Compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(50 * 8000);
    failures++;
    $display("Error watchdog expected idle seen hang");
    end_sim();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int k = 0; k < 16; k++)
      rdc(k[3:0], 8'h00);
    t_locked();
    t_unlock();
    t_erase();
    t_prog();
    t_read();
    end_sim();
  end
endmodule
`default_nettype wire
